// >>> design/wdt_defines.vh
/*
 * Constants for the watchdog and address-trap block: register offsets, bit
 * positions, reset values, control codes and timing counts.
 * Assumes it is included by bare name into plain Verilog-2005 design files.
 */
// What this block does
// - Enable bit resets to one.
// - Control register resets to 0011_1001 pattern.
// - Disable code acts only when enable is zero.
// - Counter held cleared while disabled.
// - Action bit cannot return to one once zero.
// - Overflow with action zero raises watchdog interrupt.
// - Watchdog interrupt is non-maskable.
// - New watchdog interrupt served at once, nesting.
// - Overflow with action one resets hardware briefly.
// - Reset in low-speed mode restarts fast oscillator.
// - Period field selects overflow time, fourfold steps.
// - First control register is write-only, reads undefined.
// - Watchdog and trap settings share one register.
// - RAM trap setting applies after trap-apply code.
// - Special and buffer area fetches always trap.
// - Trap action bit picks interrupt or reset.
// - Trap action zero gives non-maskable trap interrupt.
// - Trap action one resets hardware briefly.
// - Counting pauses in stop, idle, sleep.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

`define WDT_OFF_CONTROL     12'h034
`define WDT_OFF_CODE        12'h035
`define WDT_OFF_STATUS      12'h038
`define WDT_OFF_MODE        12'h03C

`define WDT_BIT_ACTION      0
`define WDT_BIT_PERIOD_LO   1
`define WDT_BIT_ENABLE      3
`define WDT_BIT_TRAP_ACTION 4
`define WDT_BIT_RAM_TRAP    5

`define WDT_RESET_CONTROL   6'h39

`define WDT_CODE_CLEAR      8'h4E
`define WDT_CODE_DISABLE    8'hB1
`define WDT_CODE_TRAP_APPLY 8'hD2

`define WDT_FAST_EXP_LONG   25
`define WDT_SLOW_EXP_LONG   17
`define WDT_RESET_CYCLES    24

`endif

// >>> design/wdt_pulse_stretch.v
/*
 * Holds an internal reset request high for a fixed number of cycles.
 * Assumes one clock and a synchronous active-low reset.
 */
module wdt_pulse_stretch #(
    parameter LENGTH = 24
) (
    // Clock and reset.
    input  wire aclk,
    input  wire aresetn,
    // Request and stretched output.
    input  wire trigger,
    output reg  active
);
    reg [7:0] count;

    // A trigger loads the count; the output stays high until it runs out.
    always @(posedge aclk) begin
        if (!aresetn) begin
            count  <= 8'h00;
            active <= 1'b0;
        end else if (trigger) begin
            count  <= LENGTH[7:0] - 8'h01;
            active <= 1'b1;
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end else begin
            active <= 1'b0;
        end
    end
endmodule

// >>> design/wdt_top.v
/*
 * Watchdog timer with address-trap control behind an AXI4-Lite slave.
 * Assumes the CPU-side signals (fetch trap strobes, power modes, clock
 * ticks) come from logic on aclk; tick inputs are one-cycle enables.
 */
`include "wdt_defines.vh"
module wdt_top #(
    parameter FAST_EXP = `WDT_FAST_EXP_LONG,
    parameter SLOW_EXP = `WDT_SLOW_EXP_LONG,
    parameter RST_LEN  = `WDT_RESET_CYCLES
) (
    // Clock and reset.
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write channels.
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read channels.
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Clock sources and power modes.
    input  wire        fast_tick,
    input  wire        slow_tick,
    input  wire        low_speed_mode,
    input  wire        clock_halt,
    // Instruction fetch classification.
    input  wire        fetch_ram,
    input  wire        fetch_special_area,
    // Events and resets.
    output reg         watchdog_interrupt,
    output reg         address_trap_interrupt,
    output wire        hardware_reset,
    output reg         fast_osc_restart
);
    // Reset image of the control byte, split into its fields below.
    localparam [5:0] RESET_CTL = `WDT_RESET_CONTROL;

    reg        overflow_action_select;
    reg [1:0]  overflow_period_select;
    reg        watchdog_enable_bit;
    reg        trap_action_select;
    reg        ram_trap_written;
    reg        ram_trap_enable;
    reg        divider_source_select;
    reg        wd_running;
    reg        wd_overflowed;
    reg [1:0]  wd_binary;
    reg [23:0] wd_divider;
    reg        aw_held;
    reg        w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    wire       use_slow;
    wire       tick;
    wire       div_carry;
    wire       overflow;
    wire       trap_hit;
    wire       wr_fire;
    wire       rst_trigger;
    wire [4:0] fast_stage;
    wire [4:0] slow_stage;

    // Address compare shared by the write and read decoders.
    function match;
        input [11:0] addr;
        input [11:0] offset;
        begin
            match = (addr[11:2] == offset[11:2]);
        end
    endfunction

    // Byte lane of the write data that belongs to a byte address.
    function [7:0] lane;
        input [31:0] data;
        input [1:0]  sel;
        begin
            lane = data[8*sel +: 8];
        end
    endfunction

    // Write channels are taken independently and held until both are in.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 12'h000;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (match(aw_addr, `WDT_OFF_CONTROL) || match(aw_addr, `WDT_OFF_MODE))
                    s_axi_bresp <= 2'b00;
                else
                    s_axi_bresp <= 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Shared control register, code register and mode register writes.
    // Control sits in byte 0 and the code register in byte 1 of one word.
    always @(posedge aclk) begin
        if (!aresetn) begin
            overflow_action_select <= RESET_CTL[`WDT_BIT_ACTION];
            overflow_period_select <= RESET_CTL[`WDT_BIT_PERIOD_LO +: 2];
            watchdog_enable_bit    <= RESET_CTL[`WDT_BIT_ENABLE];
            trap_action_select     <= RESET_CTL[`WDT_BIT_TRAP_ACTION];
            ram_trap_written       <= RESET_CTL[`WDT_BIT_RAM_TRAP];
            ram_trap_enable        <= RESET_CTL[`WDT_BIT_RAM_TRAP];
            wd_running             <= 1'b1;
            divider_source_select  <= 1'b0;
        end else if (wr_fire && match(aw_addr, `WDT_OFF_CONTROL)) begin
            if (w_strb[0]) begin
                // Once interrupt action is chosen it sticks until reset.
                overflow_action_select <= overflow_action_select & w_data[`WDT_BIT_ACTION];
                overflow_period_select <= w_data[`WDT_BIT_PERIOD_LO +: 2];
                watchdog_enable_bit    <= w_data[`WDT_BIT_ENABLE];
                trap_action_select     <= w_data[`WDT_BIT_TRAP_ACTION];
                ram_trap_written       <= w_data[`WDT_BIT_RAM_TRAP];
                if (w_data[`WDT_BIT_ENABLE])
                    wd_running <= 1'b1;
            end
            if (w_strb[1]) begin
                // Disable code counts only with the enable bit already low.
                if (lane(w_data, 2'd1) == `WDT_CODE_DISABLE && !watchdog_enable_bit)
                    wd_running <= 1'b0;
                // Pending RAM trap setting applies on the trap-apply code.
                else if (lane(w_data, 2'd1) == `WDT_CODE_TRAP_APPLY)
                    ram_trap_enable <= ram_trap_written;
                // Any other code value is dropped here.
            end
        end else if (wr_fire && match(aw_addr, `WDT_OFF_MODE) && w_strb[0]) begin
            divider_source_select <= w_data[0];
        end
    end

    // Divider runs from the selected source; it is never cleared by code.
    assign use_slow   = divider_source_select || low_speed_mode;
    assign tick       = (use_slow ? slow_tick : fast_tick) && !clock_halt;
    assign fast_stage = FAST_EXP[4:0] - 5'd2 - {2'b00, overflow_period_select, 1'b0};
    assign slow_stage = SLOW_EXP[4:0] - 5'd2 - {2'b00, overflow_period_select, 1'b0};
    assign div_carry  = tick &&
        (wd_divider[(use_slow ? slow_stage : fast_stage) - 5'd1 -: 1] == 1'b1) &&
        ((wd_divider & ((24'h00_0001 << (use_slow ? slow_stage : fast_stage)) - 24'h00_0001))
         == ((24'h00_0001 << (use_slow ? slow_stage : fast_stage)) - 24'h00_0001));
    assign overflow   = div_carry && wd_running && (wd_binary == 2'b11);

    always @(posedge aclk) begin
        if (!aresetn) begin
            wd_divider <= 24'h00_0000;
            wd_binary  <= 2'b00;
        end else begin
            if (tick)
                wd_divider <= wd_divider + 24'h00_0001;
            if (!wd_running)
                wd_binary <= 2'b00;
            else if (wr_fire && match(aw_addr, `WDT_OFF_CONTROL) && w_strb[1] &&
                     lane(w_data, 2'd1) == `WDT_CODE_CLEAR)
                wd_binary <= 2'b00;
            else if (div_carry)
                wd_binary <= wd_binary + 2'b01;
        end
    end

    // Trap detection: special areas always, RAM only when armed.
    assign trap_hit = fetch_special_area || (fetch_ram && ram_trap_enable);

    // Event pulses and the sticky overflow flag; each new pulse is raised regardless of nesting.
    always @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_interrupt     <= 1'b0;
            address_trap_interrupt <= 1'b0;
            wd_overflowed          <= 1'b0;
            fast_osc_restart       <= 1'b0;
        end else begin
            watchdog_interrupt     <= overflow && !overflow_action_select;
            address_trap_interrupt <= trap_hit && !trap_action_select;
            wd_overflowed          <= wd_overflowed || overflow;
            fast_osc_restart       <= rst_trigger && low_speed_mode;
        end
    end

    // Reset requests from either source drive a short internal reset.
    assign rst_trigger = (overflow && overflow_action_select)
                       || (trap_hit && trap_action_select);

    wdt_pulse_stretch #(
        .LENGTH (RST_LEN)
    ) u_stretch (
        .aclk    (aclk),
        .aresetn (aresetn),
        .trigger (rst_trigger),
        .active  (hardware_reset)
    );

    // Reads: control word is undefined and returns zero; status shows state.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            if (match(s_axi_araddr, `WDT_OFF_CONTROL)) begin
                s_axi_rdata <= 32'h0000_0000;
            end else if (match(s_axi_araddr, `WDT_OFF_STATUS)) begin
                s_axi_rdata <= {24'h00_0000, wd_overflowed, ram_trap_enable,
                                use_slow, wd_binary, overflow_action_select,
                                watchdog_enable_bit, wd_running};
            end else if (match(s_axi_araddr, `WDT_OFF_MODE)) begin
                s_axi_rdata <= {31'h0000_0000, divider_source_select};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> test/wdt_cpu_model.sv
/* CPU core model: an AXI4-Lite master that writes control codes and reads
   back, noting each expected answer in a queue. Assumes the bench's aclk. */
module wdt_cpu_model (
    // Clock.
    input  logic        aclk,
    // Write channels.
    output logic [11:0] s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  logic        s_axi_wready,
    input  logic        s_axi_bvalid,
    output logic        s_axi_bready,
    // Read channels.
    output logic [11:0] s_axi_araddr,
    output logic        s_axi_arvalid,
    input  logic        s_axi_arready,
    input  logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  bq[$];
    logic [34:0] rq[$];
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    end
    // Address and data go out together; each drops once taken.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        bq.push_back(2'b00);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    // Expectation holds {compare data, resp, data}.
    task automatic rd(input logic [11:0] a, input logic [34:0] e);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

// >>> test/wdt_top_assertions.sv
/* Checker for the watchdog and address-trap block, bound to its top.
   Assumes it sees only the top's ports, clocked by aclk, reset by aresetn. */
module wdt_top_chk #(
    parameter int FAST_EXP = 25,
    parameter int SLOW_EXP = 17,
    parameter int RST_LEN  = 24
) (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        fast_tick,
    input logic        slow_tick,
    input logic        low_speed_mode,
    input logic        clock_halt,
    input logic        fetch_ram,
    input logic        fetch_special_area,
    input logic        watchdog_interrupt,
    input logic        address_trap_interrupt,
    input logic        hardware_reset,
    input logic        fast_osc_restart
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned hold;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Counts how long the internal reset has been high.
    always_ff @(posedge aclk) begin
        if (!aresetn || !hardware_reset) hold <= 0;
        else hold <= hold + 1;
    end
    AST_RST_LEN: assert property ($fell(hardware_reset) |-> hold == RST_LEN)
        else $error("Internal reset held for the wrong length");
    AST_WDI_TICK: assert property (watchdog_interrupt |-> $past(fast_tick || slow_tick))
        else $error("Watchdog interrupt without a clock tick");
    AST_WDI_PULSE: assert property (watchdog_interrupt |=> !watchdog_interrupt)
        else $error("Watchdog interrupt longer than one cycle");
    AST_HALT_QUIET: assert property ($past(clock_halt) |-> !watchdog_interrupt)
        else $error("Watchdog fired while halted");
    AST_TRAP_SEEN: assert property (fetch_special_area |-> ##[1:2]
        (address_trap_interrupt || hardware_reset))
        else $error("Special area fetch did not trap");
    AST_TRAP_CAUSE: assert property (address_trap_interrupt |->
        $past(fetch_ram || fetch_special_area))
        else $error("Trap interrupt without a fetch");
    AST_OSC_RESTART: assert property (fast_osc_restart |->
        $past(low_speed_mode) ##[0:1] hardware_reset)
        else $error("Oscillator restart without a low-speed reset");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped early");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address taken while a read is pending");
    COV_WDI: cover property (watchdog_interrupt);
    COV_ATI: cover property (address_trap_interrupt);
    COV_RST: cover property ($fell(hardware_reset));
    COV_OSC: cover property (fast_osc_restart);
endmodule
bind wdt_top wdt_top_chk #(.FAST_EXP(FAST_EXP), .SLOW_EXP(SLOW_EXP),
    .RST_LEN(RST_LEN)) u_chk (.*);

// >>> test/tb.sv
/* Bench for the watchdog and address-trap block: resets it, drives ticks,
   fetches and power modes, programs it through the CPU model and counts
   events. Assumes the short sim counts FAST_EXP 9 and SLOW_EXP 7. */
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", n, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CTL = 12'h034;
    logic aclk = 0, aresetn = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_awvalid;
    logic s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, fast_tick, slow_tick, low_speed_mode, clock_halt, fetch_ram;
    logic fetch_special_area, watchdog_interrupt, address_trap_interrupt, hardware_reset;
    logic fast_osc_restart, hr_d;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed = 32'h6680_b6e8;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, b;
    logic [34:0] e;
    logic [7:0]  k;
    int error_cnt = 0, total_checks = 0, cyc = 0, n_wdi, n_ati, n_hr, n_osc, m;
    always #2.5 aclk = ~aclk;
    wdt_top #(.FAST_EXP(9), .SLOW_EXP(7)) i_dut (.*);
    wdt_cpu_model i_cpu (.*);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    // Counts events, makes random slow ticks and cuts a hang short.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        seed <= xs(seed);
        slow_tick <= seed[0];
        hr_d <= hardware_reset;
        n_wdi <= !aresetn ? 0 : n_wdi + watchdog_interrupt;
        n_ati <= !aresetn ? 0 : n_ati + address_trap_interrupt;
        n_osc <= !aresetn ? 0 : n_osc + fast_osc_restart;
        n_hr <= !aresetn ? 0 : n_hr + (hardware_reset && !hr_d);
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // Takes the oldest noted answer whenever a response is handed over.
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            b = i_cpu.bq.pop_front();
            `CHK("bresp", b, s_axi_bresp)
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = i_cpu.rq.pop_front();
            `CHK("rresp", e[33:32], s_axi_rresp)
            if (e[34]) `CHK("rdata", e[31:0], s_axi_rdata)
        end
    end
    task automatic report_and_stop;
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic rst;
        aresetn <= 0;
        gap(10);
        aresetn <= 1;
        gap(1);
    endtask
    task automatic wc(input logic [7:0] v);
        i_cpu.wr(CTL, {24'h0, v}, 4'h1);
    endtask
    task automatic wk(input logic [7:0] v);
        i_cpu.wr(CTL, {16'h0, v, 8'h0}, 4'h2);
    endtask
    task automatic fetch(input bit sp);
        if (sp) fetch_special_area <= 1;
        else fetch_ram <= 1;
        gap(1);
        {fetch_ram, fetch_special_area} <= 2'b00;
        gap(4);
    endtask
    initial begin
        {fast_tick, low_speed_mode, clock_halt, fetch_ram, fetch_special_area} = 5'b10000;
        rst;
        // Out of reset the watchdog runs; stray codes must not clear it.
        i_cpu.rd(CTL, {1'b1, 2'b00, 32'h0});
        i_cpu.rd(12'h038, {1'b1, 2'b00, 32'h0000_0047});
        i_cpu.rd(12'h0F0, {1'b0, 2'b10, 32'h0});
        gap(380);
        `CHK("early_reset", 0, n_hr)
        repeat (4) begin
            k = seed[7:0];
            wk((k inside {8'h4E, 8'hB1, 8'hD2}) ? 8'h00 : k);
        end
        gap(200);
        `CHK("wdt_reset", 1, n_hr)
        // Clearing well inside three quarters of the period keeps it quiet.
        rst;
        repeat (4) begin
            gap(300);
            wk(8'h4E);
        end
        `CHK("cleared", 0, n_hr)
        // Stack is assumed ready before the interrupt action is chosen.
        // Interrupts are only counted; no clear is sent in reply to one.
        rst;
        wc(8'h3E);
        gap(100);
        `CHK("wdi_rate", 1'b1, (n_wdi >= 10 && n_wdi <= 14))
        wc(8'h3F);
        m = n_wdi;
        gap(100);
        `CHK("action_locked", 1'b1, (n_wdi - m >= 10 && n_hr == 0))
        // Disable code while enabled is ignored; the full sequence stops it.
        wk(8'hB1);
        m = n_wdi;
        gap(50);
        `CHK("still_on", 1'b1, (n_wdi - m >= 4))
        wk(8'h4E);
        wc(8'h36);
        wk(8'hB1);
        gap(4);
        m = n_wdi;
        gap(300);
        `CHK("stopped", m, n_wdi)
        // Trap with reset action, then with interrupt action.
        rst;
        fetch(1);
        `CHK("trap_reset", 1, n_hr)
        rst;
        wc(8'h29);
        fetch(1);
        fetch(0);
        `CHK("trap_int", 2, n_ati)
        wc(8'h09);
        fetch(0);
        `CHK("ram_pending", 3, n_ati)
        wk(8'hD2);
        fetch(0);
        fetch(1);
        `CHK("ram_applied", 4, n_ati)
        `CHK("shared_reg", 0, n_hr)
        // Divider source select is a plain bit that reads back.
        i_cpu.wr(12'h03C, 32'h0000_0001, 4'h1);
        i_cpu.rd(12'h03C, {1'b1, 2'b00, 32'h0000_0001});
        // Halt pauses counting; low-speed overflow restarts the fast clock.
        rst;
        wk(8'h4E);
        clock_halt <= 1;
        gap(1000);
        `CHK("halt_hold", 0, n_hr)
        clock_halt <= 0;
        wk(8'h4E);
        low_speed_mode <= 1;
        gap(400);
        `CHK("osc_restart", 1, n_osc)
        `CHK("slow_reset", 1, n_hr)
        report_and_stop();
    end
endmodule
